// ==== rtl/wdsr_pkg.sv ====
package wdsr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register addresses in the special function space
    localparam logic [7:0] SFR_ADDR_KEY = 8'ha6;
    localparam logic [7:0] SFR_ADDR_CTRL = 8'ha7;

    ////////////////////////////////////////////////////////////////////////////
    // Key bytes
    localparam logic [7:0] KEY_FEED_FIRST = 8'h1e;
    localparam logic [7:0] KEY_FEED_SECOND = 8'he1;
    localparam logic [7:0] KEY_SOFT_FIRST = 8'h5a;
    localparam logic [7:0] KEY_SOFT_SECOND = 8'ha5;

    ////////////////////////////////////////////////////////////////////////////
    // Control register layout
    localparam int CTRL_PS_MSB = 7;
    localparam int CTRL_PS_LSB = 5;
    localparam int CTRL_IDLE_BIT = 4;
    localparam int CTRL_SOFT_BIT = 2;
    localparam int CTRL_OVF_BIT = 1;
    localparam int CTRL_RUN_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [2:0] PS_RESET = 3'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Counting chain
    localparam int PS_W = 3;
    localparam int PRESCALE_W = 7;
    localparam int TIMER_W = 14;
    localparam logic [4:0] PERIOD_BASE_EXP = 5'h0e;

    ////////////////////////////////////////////////////////////////////////////
    // Key sequence states
    typedef enum logic [2:0] {
        KS_IDLE = 3'b001,
        KS_FEED = 3'b010,
        KS_SOFT = 3'b100
    } wdsr_key_state_t;

endpackage : wdsr_pkg

// ==== rtl/wdsr_counter.sv ====
`timescale 1ns/10ps
module wdsr_counter #(
    parameter int TPS_W = 4
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_clear,
    input wire logic i_run,
    input wire logic [wdsr_pkg::PS_W-1:0] i_ps,
    input wire logic [TPS_W-1:0] i_tps,
    output logic o_timeout
);

    logic [TPS_W-1:0] tps_cnt_reg;
    logic [wdsr_pkg::PRESCALE_W-1:0] pre_cnt_reg;
    logic [wdsr_pkg::TIMER_W-1:0] timer_reg;
    logic [wdsr_pkg::PRESCALE_W-1:0] pre_mask;
    logic tps_tick;
    logic pre_tick;

    ////////////////////////////////////////////////////////////////////////////
    // System prescale stretches every clock by tps+1
    assign tps_tick = i_run && (tps_cnt_reg >= i_tps);
    // Masked compare so a period change mid count cannot wrap past 128
    assign pre_mask = wdsr_pkg::PRESCALE_W'((8'h01 << i_ps) - 8'h01);
    assign pre_tick = tps_tick && ((pre_cnt_reg & pre_mask) == pre_mask);
    assign o_timeout = pre_tick && (timer_reg == {wdsr_pkg::TIMER_W{1'b1}});

    always_ff @(posedge i_clk) begin
        if (!i_rst_n || i_clear) begin
            tps_cnt_reg <= '0;
        end else if (tps_tick) begin
            tps_cnt_reg <= '0;
        end else if (i_run) begin
            tps_cnt_reg <= TPS_W'(tps_cnt_reg + 1'b1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n || i_clear) begin
            pre_cnt_reg <= '0;
        end else if (pre_tick) begin
            pre_cnt_reg <= '0;
        end else if (tps_tick) begin
            pre_cnt_reg <= wdsr_pkg::PRESCALE_W'(pre_cnt_reg + 1'b1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n || i_clear) begin
            timer_reg <= '0;
        end else if (pre_tick) begin
            timer_reg <= wdsr_pkg::TIMER_W'(timer_reg + 1'b1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helper for the period check
    logic [31:0] run_cnt_reg;
    logic cfg_stable_reg;
    logic [31:0] expected;
    assign expected = ({{(32 - TPS_W){1'b0}}, i_tps} + 32'h1)
        << (5'(i_ps) + wdsr_pkg::PERIOD_BASE_EXP);

    always_ff @(posedge i_clk) begin
        if (!i_rst_n || i_clear) begin
            run_cnt_reg <= 32'h0;
            cfg_stable_reg <= 1'b1;
        end else begin
            if (i_run) begin
                run_cnt_reg <= run_cnt_reg + 32'h1;
            end
            if ($changed(i_ps) || $changed(i_tps)) begin
                cfg_stable_reg <= 1'b0;
            end
        end
    end

    a_period_exact: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (o_timeout && cfg_stable_reg && !$changed(i_ps) && !$changed(i_tps))
        |-> (run_cnt_reg == expected - 32'h1))
        else $error("Time-out not at the selected period");

    a_frozen_chain: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!i_run && !i_clear) |=> ($stable(timer_reg) && $stable(pre_cnt_reg)))
        else $error("Chain moved while not running");

endmodule : wdsr_counter

// ==== rtl/wdsr_key_seq.sv ====
`timescale 1ns/10ps
module wdsr_key_seq (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_clear,
    input wire logic i_key_wr,
    input wire logic i_other_wr,
    input wire logic [7:0] i_data,
    output logic o_feed_ok,
    output logic o_soft_ok,
    output logic o_bad
);

    wdsr_pkg::wdsr_key_state_t state_reg;
    wdsr_pkg::wdsr_key_state_t state_next;

    always_comb begin
        state_next = state_reg;
        o_feed_ok = 1'b0;
        o_soft_ok = 1'b0;
        o_bad = 1'b0;
        case (state_reg)
            wdsr_pkg::KS_IDLE: begin
                if (i_key_wr) begin
                    if (i_data == wdsr_pkg::KEY_FEED_FIRST) begin
                        state_next = wdsr_pkg::KS_FEED;
                    end else if (i_data == wdsr_pkg::KEY_SOFT_FIRST) begin
                        state_next = wdsr_pkg::KS_SOFT;
                    end else begin
                        o_bad = 1'b1;
                    end
                end
            end
            wdsr_pkg::KS_FEED: begin
                if (i_other_wr) begin
                    o_bad = 1'b1;
                    state_next = wdsr_pkg::KS_IDLE;
                end else if (i_key_wr) begin
                    state_next = wdsr_pkg::KS_IDLE;
                    o_feed_ok = (i_data == wdsr_pkg::KEY_FEED_SECOND);
                    o_bad = (i_data != wdsr_pkg::KEY_FEED_SECOND);
                end
            end
            wdsr_pkg::KS_SOFT: begin
                if (i_other_wr) begin
                    o_bad = 1'b1;
                    state_next = wdsr_pkg::KS_IDLE;
                end else if (i_key_wr) begin
                    state_next = wdsr_pkg::KS_IDLE;
                    o_soft_ok = (i_data == wdsr_pkg::KEY_SOFT_SECOND);
                    o_bad = (i_data != wdsr_pkg::KEY_SOFT_SECOND);
                end
            end
            default: begin
                state_next = wdsr_pkg::KS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n || i_clear) begin
            state_reg <= wdsr_pkg::KS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    a_gap_write_breaks: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_reg != wdsr_pkg::KS_IDLE && i_other_wr && !i_clear) |-> o_bad)
        else $error("Gap write did not break the sequence");

endmodule : wdsr_key_seq

// ==== rtl/wdsr_top.sv ====
`timescale 1ns/10ps
module wdsr_top #(
    parameter int TPS_W = 4
) (
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic I_EXT_RESET,
    input wire logic [7:0] I_SFR_ADDR,
    input wire logic [7:0] I_SFR_WDATA,
    input wire logic I_SFR_WR,
    input wire logic I_SFR_RD,
    input wire logic I_IDLE,
    input wire logic I_POWER_DOWN,
    input wire logic [TPS_W-1:0] I_SYSTEM_TIMER_PRESCALE,
    output logic [7:0] O_SFR_RDATA,
    output logic O_CHIP_RST,
    output logic O_RUNNING
);

    ////////////////////////////////////////////////////////////////////////////
    // State
    logic [wdsr_pkg::PS_W-1:0] period_select_reg;
    logic idle_freeze_reg;
    logic soft_reset_flag_reg;
    logic overflow_flag_reg;
    logic running_status_reg;
    logic chip_rst_reg;
    logic [7:0] rdata_reg;

    logic key_wr;
    logic ctrl_wr;
    logic other_wr;
    logic ctrl_rd;
    logic feed_ok;
    logic soft_ok;
    logic seq_bad;
    logic timeout;
    logic rst_evt;
    logic any_reset;
    logic chain_run;
    logic chain_clear;
    logic [7:0] ctrl_value;

    ////////////////////////////////////////////////////////////////////////////
    // Decode
    assign key_wr = I_SFR_WR && (I_SFR_ADDR == wdsr_pkg::SFR_ADDR_KEY);
    assign ctrl_wr = I_SFR_WR && (I_SFR_ADDR == wdsr_pkg::SFR_ADDR_CTRL);
    // Any write away from the key port counts against a half sequence
    assign other_wr = I_SFR_WR && !key_wr;
    assign ctrl_rd = I_SFR_RD && (I_SFR_ADDR == wdsr_pkg::SFR_ADDR_CTRL);

    // Soft and error resets need no enable
    assign rst_evt = seq_bad || soft_ok || timeout;
    // Internal pulse is fed back so the block clears itself like the core
    assign any_reset = chip_rst_reg || I_EXT_RESET;
    assign chain_run = running_status_reg && !I_POWER_DOWN
        && !(I_IDLE && idle_freeze_reg);
    assign chain_clear = feed_ok || !running_status_reg || any_reset || rst_evt;

    assign ctrl_value = {period_select_reg, idle_freeze_reg, 1'b0,
        soft_reset_flag_reg, overflow_flag_reg, running_status_reg};

    ////////////////////////////////////////////////////////////////////////////
    // Submodules
    wdsr_key_seq u_key_seq (
        .i_clk(I_CLK),
        .i_rst_n(I_RST_N),
        .i_clear(any_reset),
        .i_key_wr(key_wr),
        .i_other_wr(other_wr),
        .i_data(I_SFR_WDATA),
        .o_feed_ok(feed_ok),
        .o_soft_ok(soft_ok),
        .o_bad(seq_bad)
    );

    wdsr_counter #(
        .TPS_W(TPS_W)
    ) u_counter (
        .i_clk(I_CLK),
        .i_rst_n(I_RST_N),
        .i_clear(chain_clear),
        .i_run(chain_run),
        .i_ps(period_select_reg),
        .i_tps(I_SYSTEM_TIMER_PRESCALE),
        .o_timeout(timeout)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Configuration fields
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N || any_reset) begin
            period_select_reg <= wdsr_pkg::PS_RESET;
            idle_freeze_reg <= wdsr_pkg::CTRL_RESET[wdsr_pkg::CTRL_IDLE_BIT];
        end else if (ctrl_wr) begin
            period_select_reg <= I_SFR_WDATA[wdsr_pkg::CTRL_PS_MSB:wdsr_pkg::CTRL_PS_LSB];
            idle_freeze_reg <= I_SFR_WDATA[wdsr_pkg::CTRL_IDLE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Enable status, never written by software
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N || any_reset || rst_evt) begin
            running_status_reg <= 1'b0;
        end else if (feed_ok) begin
            running_status_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cause flags survive the internal reset; a set beats a clear
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            soft_reset_flag_reg <= wdsr_pkg::CTRL_RESET[wdsr_pkg::CTRL_SOFT_BIT];
        end else if (seq_bad || soft_ok) begin
            soft_reset_flag_reg <= 1'b1;
        end else if (ctrl_wr && !I_SFR_WDATA[wdsr_pkg::CTRL_SOFT_BIT]) begin
            soft_reset_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            overflow_flag_reg <= wdsr_pkg::CTRL_RESET[wdsr_pkg::CTRL_OVF_BIT];
        end else if (seq_bad || timeout) begin
            overflow_flag_reg <= 1'b1;
        end else if (ctrl_wr && !I_SFR_WDATA[wdsr_pkg::CTRL_OVF_BIT]) begin
            overflow_flag_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset pulse, one cycle
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            chip_rst_reg <= 1'b0;
        end else begin
            chip_rst_reg <= rst_evt && !chip_rst_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port; key port is write only and reads zero
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            rdata_reg <= 8'h00;
        end else if (ctrl_rd) begin
            rdata_reg <= ctrl_value;
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    assign O_SFR_RDATA = rdata_reg;
    assign O_CHIP_RST = chip_rst_reg;
    assign O_RUNNING = running_status_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Second key decode, kept apart so a sequencer slip shows up
    logic [7:0] shadow_first_reg;
    logic shadow_armed_reg;
    logic shadow_feed;
    logic shadow_soft;
    logic shadow_bad;

    assign shadow_feed = shadow_armed_reg && key_wr
        && (shadow_first_reg == wdsr_pkg::KEY_FEED_FIRST)
        && (I_SFR_WDATA == wdsr_pkg::KEY_FEED_SECOND);
    assign shadow_soft = shadow_armed_reg && key_wr
        && (shadow_first_reg == wdsr_pkg::KEY_SOFT_FIRST)
        && (I_SFR_WDATA == wdsr_pkg::KEY_SOFT_SECOND);
    assign shadow_bad = shadow_armed_reg
        ? ((key_wr || other_wr) && !shadow_feed && !shadow_soft)
        : (key_wr && (I_SFR_WDATA != wdsr_pkg::KEY_FEED_FIRST)
        && (I_SFR_WDATA != wdsr_pkg::KEY_SOFT_FIRST));

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N || any_reset) begin
            shadow_armed_reg <= 1'b0;
            shadow_first_reg <= 8'h00;
        end else if (key_wr && !shadow_armed_reg) begin
            shadow_armed_reg <= !shadow_bad;
            shadow_first_reg <= I_SFR_WDATA;
        end else if (key_wr || other_wr) begin
            shadow_armed_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_feed_enables: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (feed_ok && !any_reset) |=> (running_status_reg && !O_CHIP_RST))
        else $error("Feed did not enable the watchdog");

    a_timeout_resets: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (timeout && !chip_rst_reg) |=> ((O_CHIP_RST && overflow_flag_reg)
        ##1 !running_status_reg))
        else $error("Time-out did not reset and flag");

    a_bad_both_flags: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (seq_bad && !chip_rst_reg) |=> (O_CHIP_RST && soft_reset_flag_reg
        && overflow_flag_reg))
        else $error("Bad sequence did not set both flags");

    a_soft_no_enable: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (soft_ok && !running_status_reg && !chip_rst_reg)
        |=> (O_CHIP_RST && soft_reset_flag_reg))
        else $error("Software reset ignored while disabled");

    a_soft_keeps_ovf: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (soft_ok && !timeout && !overflow_flag_reg) |=> !overflow_flag_reg)
        else $error("Software reset set the overflow flag");

    a_flags_persist: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (overflow_flag_reg && !ctrl_wr) |=> overflow_flag_reg)
        else $error("Overflow flag lost without a clear");

    a_status_readonly: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (ctrl_wr && !feed_ok && !rst_evt && !any_reset) |=> $stable(running_status_reg))
        else $error("Software write changed the running status");

    a_reset_disables: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        O_CHIP_RST |-> !running_status_reg ##1 !running_status_reg)
        else $error("Watchdog still enabled after reset");

    a_powerdown_stop: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        I_POWER_DOWN |-> !timeout)
        else $error("Time-out during power-down");

    a_idle_freeze: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (I_IDLE && idle_freeze_reg) |-> !chain_run)
        else $error("Watchdog counted in frozen idle");

    a_read_status: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        ctrl_rd |=> (O_SFR_RDATA[wdsr_pkg::CTRL_RUN_BIT] == $past(running_status_reg)))
        else $error("Read status does not match running state");

    a_shadow_feed: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        feed_ok == shadow_feed)
        else $error("Feed decode differs from the shadow");

    a_shadow_soft: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        soft_ok == shadow_soft)
        else $error("Soft reset decode differs from the shadow");

    a_shadow_bad: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        seq_bad == shadow_bad)
        else $error("Bad sequence decode differs from the shadow");

    a_soft_persist: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (soft_reset_flag_reg && !ctrl_wr) |=> soft_reset_flag_reg)
        else $error("Soft reset flag lost without a clear");

    a_ovf_clear: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (ctrl_wr && !I_SFR_WDATA[wdsr_pkg::CTRL_OVF_BIT] && !seq_bad && !timeout)
        |=> !overflow_flag_reg)
        else $error("Overflow flag not cleared by software");

    a_soft_clear: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (ctrl_wr && !I_SFR_WDATA[wdsr_pkg::CTRL_SOFT_BIT] && !seq_bad && !soft_ok)
        |=> !soft_reset_flag_reg)
        else $error("Soft reset flag not cleared by software");

    a_pulse_single: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        O_CHIP_RST |=> !O_CHIP_RST)
        else $error("Reset pulse longer than one cycle");

    a_no_spurious_rst: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        !rst_evt |=> !O_CHIP_RST)
        else $error("Reset pulse without a cause");

    a_ovf_cause: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (!overflow_flag_reg && !seq_bad && !timeout) |=> !overflow_flag_reg)
        else $error("Overflow flag set without a cause");

    a_soft_cause: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (!soft_reset_flag_reg && !seq_bad && !soft_ok) |=> !soft_reset_flag_reg)
        else $error("Soft reset flag set without a cause");

    a_run_needs_feed: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        (!running_status_reg && !feed_ok) |=> !running_status_reg)
        else $error("Watchdog started without a feed");

    a_read_ps: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        ctrl_rd |=> (O_SFR_RDATA[wdsr_pkg::CTRL_PS_MSB:wdsr_pkg::CTRL_PS_LSB]
        == $past(period_select_reg)))
        else $error("Read period select does not match");

    a_read_idle: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        ctrl_rd |=> (O_SFR_RDATA[wdsr_pkg::CTRL_IDLE_BIT] == $past(idle_freeze_reg)))
        else $error("Read idle freeze does not match");

    a_read_flags: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        ctrl_rd |=> (O_SFR_RDATA[wdsr_pkg::CTRL_SOFT_BIT] == $past(soft_reset_flag_reg)
        && O_SFR_RDATA[wdsr_pkg::CTRL_OVF_BIT] == $past(overflow_flag_reg)))
        else $error("Read cause flags do not match");

    a_read_zero: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        !ctrl_rd |=> (O_SFR_RDATA == 8'h00))
        else $error("Read data not zero outside a control read");

    a_cfg_cleared: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        any_reset |=> ((period_select_reg == wdsr_pkg::PS_RESET) && !idle_freeze_reg))
        else $error("Reset left the configuration set");

    a_feed_restart: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        feed_ok |=> !timeout)
        else $error("Time-out right after a feed");

    a_disabled_quiet: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        !running_status_reg |-> !timeout)
        else $error("Time-out while disabled");

    a_ext_disables: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        I_EXT_RESET |=> !running_status_reg)
        else $error("External reset left the watchdog running");

    a_soft_stops_run: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        soft_ok |=> !running_status_reg)
        else $error("Software reset left the watchdog running");

    a_bad_stops_run: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        seq_bad |=> !running_status_reg)
        else $error("Bad sequence left the watchdog running");

endmodule : wdsr_top

// ==== sim/tb.sv ====
`timescale 1ns/10ps
`define CHK(got, exp) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        failures++; \
        $display("MISMATCH at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
end

module tb;
    localparam logic [7:0] KA = wdsr_pkg::SFR_ADDR_KEY;
    localparam logic [7:0] CA = wdsr_pkg::SFR_ADDR_CTRL;
    logic I_CLK = 1'b0;
    logic I_RST_N = 1'b0;
    logic I_EXT_RESET = 1'b0;
    logic [7:0] I_SFR_ADDR = 8'h00;
    logic [7:0] I_SFR_WDATA = 8'h00;
    logic I_SFR_WR = 1'b0;
    logic I_SFR_RD = 1'b0;
    logic I_IDLE = 1'b0;
    logic I_POWER_DOWN = 1'b0;
    logic [3:0] I_SYSTEM_TIMER_PRESCALE = 4'h0;
    logic [7:0] O_SFR_RDATA;
    logic O_CHIP_RST;
    logic O_RUNNING;
    int failures = 0;
    int total_checks = 0;
    int cyc = 0;
    int npulse = 0;
    int t0;
    int el;
    int np0;
    // Broken sequences: first byte, then address and data of the closing write
    logic [7:0] bad_first [5] = '{8'h1e, 8'h5a, 8'h1e, 8'h1e, 8'h1e};
    logic [7:0] bad_addr [5] = '{KA, KA, KA, 8'h80, CA};
    logic [7:0] bad_data [5] = '{8'h33, 8'he1, 8'ha5, 8'h00, 8'h00};

    wdsr_top #(.TPS_W(4)) u_wdsr_top (
        .I_CLK(I_CLK),
        .I_RST_N(I_RST_N),
        .I_EXT_RESET(I_EXT_RESET),
        .I_SFR_ADDR(I_SFR_ADDR),
        .I_SFR_WDATA(I_SFR_WDATA),
        .I_SFR_WR(I_SFR_WR),
        .I_SFR_RD(I_SFR_RD),
        .I_IDLE(I_IDLE),
        .I_POWER_DOWN(I_POWER_DOWN),
        .I_SYSTEM_TIMER_PRESCALE(I_SYSTEM_TIMER_PRESCALE),
        .O_SFR_RDATA(O_SFR_RDATA),
        .O_CHIP_RST(O_CHIP_RST),
        .O_RUNNING(O_RUNNING)
    );

    always #4 I_CLK = ~I_CLK;

    always @(posedge I_CLK) begin
        cyc <= cyc + 1;
        if (O_CHIP_RST === 1'b1) begin
            npulse <= npulse + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("Checks %0d, failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    // Returns just after the edge that takes the write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge I_CLK);
        I_SFR_ADDR <= a;
        I_SFR_WDATA <= d;
        I_SFR_WR <= 1'b1;
        @(posedge I_CLK);
        I_SFR_WR <= 1'b0;
    endtask : wr

    task automatic ck_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge I_CLK);
        I_SFR_ADDR <= a;
        I_SFR_RD <= 1'b1;
        @(posedge I_CLK);
        I_SFR_RD <= 1'b0;
        #1;
        `CHK(O_SFR_RDATA, exp)
    endtask : ck_rd

    task automatic key(input logic [7:0] b1, input logic [7:0] b2);
        wr(KA, b1);
        wr(KA, b2);
    endtask : key

    // Pulse high in the cycle after the taking edge, low one cycle later
    task automatic pulse;
        #1;
        `CHK(O_CHIP_RST, 1'b1)
        @(posedge I_CLK);
        #1;
        `CHK(O_CHIP_RST, 1'b0)
    endtask : pulse

    // Bounded wait for the time-out pulse; lo is the expected elapsed cycle count since t0
    task automatic run_out(input int lo);
        while (O_CHIP_RST !== 1'b1) begin
            if (cyc - t0 > lo + 10) begin
                failures++;
                $display("MISMATCH at %0t: no time-out pulse", $time);
                end_of_test();
            end
            @(posedge I_CLK);
            #1;
        end
        el = cyc - t0;
        `CHK((el >= lo) && (el <= lo + 2), 1'b1)
    endtask : run_out

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge I_CLK);
        I_RST_N <= 1'b1;
        ck_rd(CA, 8'h00);
        ck_rd(KA, 8'h00);
        ck_rd(8'h80, 8'h00);
        wr(CA, 8'hff);
        ck_rd(CA, 8'hf0);
        wr(CA, 8'h10);
        key(8'h1e, 8'he1);
        #1;
        `CHK(O_RUNNING, 1'b1)
        ck_rd(CA, 8'h11);
        // Refeed well inside the period; no pulse may appear
        np0 = npulse;
        repeat (8000) @(posedge I_CLK);
        `CHK(npulse, np0)
        key(8'h1e, 8'he1);
        #1;
        t0 = cyc;
        @(posedge I_CLK);
        I_POWER_DOWN <= 1'b1;
        repeat (1000) @(posedge I_CLK);
        I_POWER_DOWN <= 1'b0;
        I_IDLE <= 1'b1;
        repeat (500) @(posedge I_CLK);
        I_IDLE <= 1'b0;
        run_out(16384 + 1000 + 500);
        ck_rd(CA, 8'h02);
        `CHK(O_RUNNING, 1'b0)
        wr(CA, 8'h02);
        ck_rd(CA, 8'h02);
        wr(CA, 8'h00);
        ck_rd(CA, 8'h00);
        // Longest run kept short: select 1 and prescale 1, idle with no freeze
        wr(CA, 8'h20);
        @(posedge I_CLK);
        I_SYSTEM_TIMER_PRESCALE <= 4'h1;
        I_IDLE <= 1'b1;
        key(8'h1e, 8'he1);
        #1;
        t0 = cyc;
        run_out(2 * 32768);
        @(posedge I_CLK);
        I_SYSTEM_TIMER_PRESCALE <= 4'h0;
        I_IDLE <= 1'b0;
        wr(CA, 8'h00);
        wr(KA, 8'h33);
        pulse();
        ck_rd(CA, 8'h06);
        for (int i = 0; i < 5; i++) begin
            wr(CA, 8'h00);
            wr(KA, bad_first[i]);
            wr(bad_addr[i], bad_data[i]);
            pulse();
            ck_rd(CA, 8'h06);
        end
        // A read between the key bytes keeps the sequence alive
        wr(KA, 8'h1e);
        ck_rd(CA, 8'h06);
        wr(KA, 8'he1);
        #1;
        `CHK(O_CHIP_RST, 1'b0)
        `CHK(O_RUNNING, 1'b1)
        @(posedge I_CLK);
        I_EXT_RESET <= 1'b1;
        @(posedge I_CLK);
        I_EXT_RESET <= 1'b0;
        repeat (2) @(posedge I_CLK);
        #1;
        `CHK(O_RUNNING, 1'b0)
        ck_rd(CA, 8'h06);
        wr(CA, 8'h00);
        key(8'h5a, 8'ha5);
        pulse();
        ck_rd(CA, 8'h04);
        `CHK(O_RUNNING, 1'b0)
        @(posedge I_CLK);
        I_RST_N <= 1'b0;
        @(posedge I_CLK);
        I_RST_N <= 1'b1;
        ck_rd(CA, 8'h00);
        end_of_test();
    end
endmodule : tb
